// ### verilog/mac_cfg_regs.svh
// What this block does
// - Transmit speed code 00 selects 10 Mb/s, 01 100 Mb/s, 10 gigabit.
// - Low-speed-only build decides speed from bit 12 alone, ignoring bit 13.
// - Gigabit-only build ignores the transmit speed field entirely.
// - Gap adjust bit 8 with full duplex sizes gap from port; else legal minimum.
// - Bit 6 selects half duplex; ignored in builds without half duplex.
// - Flow control bit 5 set lets pause requests send pause frames; clear ignores them.
// - Jumbo bit 4 lifts length limit; clear defers to max-frame enable and length.
// - In-band FCS bit 3: user supplies FCS and padding; clear: MAC pads, appends FCS.
// - VLAN bit 2 permits tagged frames up to 1522 bytes.
// - Transmit enable bit 1 makes transmitter operational; clear disables it.
// - Transmit reset bit 0 holds transmitter in reset, feeding its reset circuit.
// - Receive bits 79:32 hold station address for pause match and pause source.
// - Address LSB sits in field bit 0; bits 7:0 are first byte on wire.
// - Receive bits 31:16 set limit with max enable and no jumbo; at least 1518.
// - Vector changes apply after the current frame ends; resets act at once.
// - Transmit bit 14 without jumbo allows frames up to programmed length, else legal.
// - Transmit bits 79:32 hold address for pause matching and pause source.
// - Receive bit 14 without jumbo passes frames up to receive limit, else legal.
`ifndef MAC_CFG_REGS_SVH
`define MAC_CFG_REGS_SVH

// Register word indices; byte address is four times the index
`define IDX_TX_CTRL 3'h0
`define IDX_TX_ADDR_LO 3'h1
`define IDX_TX_ADDR_HI 3'h2
`define IDX_RX_CTRL 3'h3
`define IDX_RX_ADDR_LO 3'h4
`define IDX_RX_ADDR_HI 3'h5
`define IDX_STATUS 3'h6

// Writable bit masks; all other bits are reserved and read zero
`define TX_CTRL_MASK 32'hffff_717f
`define RX_CTRL_MASK 32'hffff_4010
`define ADDR_HI_MASK 32'h0000_ffff

// Reset values: maximum length 1518, everything else off
`define TX_CTRL_RST 32'h05ee_0000
`define RX_CTRL_RST 32'h05ee_0000

// Field positions in the control words
`define B_RESET 0
`define B_ENABLE 1
`define B_VLAN 2
`define B_FCS 3
`define B_JUMBO 4
`define B_FLOWCTL 5
`define B_HALF 6
`define B_IFG 8
`define B_SPD_LO 12
`define B_SPD_HI 13
`define B_MAXEN 14
`define F_MAXLEN_HI 31
`define F_MAXLEN_LO 16

// Frame lengths in bytes
`define LEN_LEGAL 16'h05ee
`define LEN_VLAN 16'h05f2
`define LEN_MIN_USER 16'h0040

// Build options for speed support
`define BUILD_TRI 0
`define BUILD_LOW 1
`define BUILD_GIG 2

`endif

// ### verilog/mac_cfg_pkg.sv
package mac_cfg_pkg;

	typedef enum logic [1:0] {
		SPEED_10 = 2'h0,
		SPEED_100 = 2'h1,
		SPEED_1000 = 2'h2
	} speed_type;

	typedef struct packed {
		logic reset;
		logic enable;
		speed_type speed;
		logic half_duplex;
		logic ifg_from_port;
		logic pause_enable;
		logic len_unlimited;
		logic [15:0] len_limit;
		logic user_fcs;
		logic mac_pad_fcs;
		logic [15:0] user_min_len;
		logic [47:0] station_addr;
	} tx_cfg_type;

	typedef struct packed {
		logic len_unlimited;
		logic [15:0] len_limit;
		logic [47:0] station_addr;
	} rx_cfg_type;

endpackage

// ### verilog/cfg_apply.sv
`timescale 1ns/10ps
`default_nettype none
// Holds the working copy of a vector; loads the staged copy only between frames
module cfg_apply #(
	parameter int W = 32,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Staged value and frame state
	input wire logic [W-1:0] staged,
	input wire logic frame_active,
	// Working value
	output logic [W-1:0] applied,
	output logic pending
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			applied <= RST;
		end else if (!frame_active) begin
			applied <= staged;
		end
	end

	assign pending = (staged != applied);
endmodule
`default_nettype wire

// ### verilog/mac_cfg_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "mac_cfg_regs.svh"
module mac_cfg_regs import mac_cfg_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int SPEED_BUILD = `BUILD_TRI,
	parameter bit HALF_DUPLEX_OK = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Frame state from the MAC
	input wire logic tx_frame_active,
	input wire logic rx_frame_active,
	// Pause request from the user
	input wire logic pause_req,
	// Decoded settings to the MAC
	output tx_cfg_type tx_cfg,
	output rx_cfg_type rx_cfg,
	output logic pause_send
);
	// Refused at elaboration: the decoder needs address bits 4:2 and a known build
	if (ADDR_W < 5 || ADDR_W > 32)
		$error("ADDR_W must be 5 to 32");
	if (SPEED_BUILD < `BUILD_TRI || SPEED_BUILD > `BUILD_GIG)
		$error("SPEED_BUILD out of range");

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Returns the word index, or 7 for an address that maps to nothing
	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] hi;
		hi = a >> 5;
		if (hi != '0 || a[4:2] == 3'h7)
			reg_index = 3'h7;
		else
			reg_index = a[4:2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = ((old & ~m) | (nw & m)) & mask;
	endfunction

	// Software-visible registers
	logic [31:0] tx_ctrl_r, tx_addr_lo_r, tx_addr_hi_r;
	logic [31:0] rx_ctrl_r, rx_addr_lo_r, rx_addr_hi_r;

	// Write channel state
	logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r;
	logic [1:0] bresp_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;

	wire aw_take = s_axi_awvalid & awready_r;
	wire w_take = s_axi_wvalid & wready_r;
	wire do_write = aw_full_r & w_full_r & ~bvalid_r;
	wire b_done = bvalid_r & s_axi_bready;
	wire aw_full_nxt = aw_take | (aw_full_r & ~do_write);
	wire w_full_nxt = w_take | (w_full_r & ~do_write);
	wire bvalid_nxt = do_write | (bvalid_r & ~b_done);
	wire [2:0] wr_idx = reg_index(awaddr_r);
	wire wr_map = (wr_idx != 3'h7);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			awready_r <= ~aw_full_nxt & ~bvalid_nxt;
			wready_r <= ~w_full_nxt & ~bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			if (do_write)
				bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (aw_take)
			awaddr_r <= s_axi_awaddr;
		if (w_take) begin
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_ctrl_r <= `TX_CTRL_RST;
			tx_addr_lo_r <= '0;
			tx_addr_hi_r <= '0;
			rx_ctrl_r <= `RX_CTRL_RST;
			rx_addr_lo_r <= '0;
			rx_addr_hi_r <= '0;
		end else if (do_write) begin
			case (wr_idx)
				`IDX_TX_CTRL: tx_ctrl_r <= merge(tx_ctrl_r, wdata_r, wstrb_r, `TX_CTRL_MASK);
				`IDX_TX_ADDR_LO: tx_addr_lo_r <= merge(tx_addr_lo_r, wdata_r, wstrb_r, '1);
				`IDX_TX_ADDR_HI: tx_addr_hi_r <= merge(tx_addr_hi_r, wdata_r, wstrb_r, `ADDR_HI_MASK);
				`IDX_RX_CTRL: rx_ctrl_r <= merge(rx_ctrl_r, wdata_r, wstrb_r, `RX_CTRL_MASK);
				`IDX_RX_ADDR_LO: rx_addr_lo_r <= merge(rx_addr_lo_r, wdata_r, wstrb_r, '1);
				`IDX_RX_ADDR_HI: rx_addr_hi_r <= merge(rx_addr_hi_r, wdata_r, wstrb_r, `ADDR_HI_MASK);
				default: ;
			endcase
		end
	end

	// Frame-boundary copies; the reset bit is kept out so it is never delayed
	logic [79:0] tx_vec, rx_vec;
	logic tx_pending, rx_pending;
	wire [79:0] tx_staged = {tx_addr_hi_r[15:0], tx_addr_lo_r, tx_ctrl_r[31:1], 1'b0};
	wire [79:0] rx_staged = {rx_addr_hi_r[15:0], rx_addr_lo_r, rx_ctrl_r};

	cfg_apply #(.W(80), .RST({48'h0, `TX_CTRL_RST})) u_tx_apply (
		.aclk(aclk),
		.aresetn(aresetn),
		.staged(tx_staged),
		.frame_active(tx_frame_active),
		.applied(tx_vec),
		.pending(tx_pending)
	);

	cfg_apply #(.W(80), .RST({48'h0, `RX_CTRL_RST})) u_rx_apply (
		.aclk(aclk),
		.aresetn(aresetn),
		.staged(rx_staged),
		.frame_active(rx_frame_active),
		.applied(rx_vec),
		.pending(rx_pending)
	);

	// Transmit decode
	wire [1:0] spd_code = {tx_vec[`B_SPD_HI], tx_vec[`B_SPD_LO]};
	wire speed_type spd_tri = (spd_code == 2'h0) ? SPEED_10 :
		(spd_code == 2'h1) ? SPEED_100 : SPEED_1000;
	wire speed_type spd_low = tx_vec[`B_SPD_LO] ? SPEED_100 : SPEED_10;
	wire speed_type spd_eff = (SPEED_BUILD == `BUILD_GIG) ? SPEED_1000 :
		(SPEED_BUILD == `BUILD_LOW) ? spd_low : spd_tri;
	wire half_eff = HALF_DUPLEX_OK & tx_vec[`B_HALF];
	wire ifg_eff = tx_vec[`B_IFG] & ~half_eff;
	wire tx_jumbo = tx_vec[`B_JUMBO];
	wire [15:0] tx_legal = tx_vec[`B_VLAN] ? `LEN_VLAN : `LEN_LEGAL;
	wire [15:0] tx_limit = tx_vec[`B_MAXEN] ?
		tx_vec[`F_MAXLEN_HI:`F_MAXLEN_LO] : tx_legal;
	wire user_fcs = tx_vec[`B_FCS];

	// Receive decode; the programmed limit is trusted to be at least 1518
	wire rx_jumbo = rx_vec[`B_JUMBO];
	wire [15:0] rx_limit = rx_vec[`B_MAXEN] ?
		rx_vec[`F_MAXLEN_HI:`F_MAXLEN_LO] : `LEN_LEGAL;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_cfg <= '0;
			rx_cfg <= '0;
			pause_send <= 1'b0;
		end else begin
			tx_cfg.reset <= tx_ctrl_r[`B_RESET];
			tx_cfg.enable <= tx_vec[`B_ENABLE];
			tx_cfg.speed <= spd_eff;
			tx_cfg.half_duplex <= half_eff;
			tx_cfg.ifg_from_port <= ifg_eff;
			tx_cfg.pause_enable <= tx_vec[`B_FLOWCTL];
			tx_cfg.len_unlimited <= tx_jumbo;
			tx_cfg.len_limit <= tx_limit;
			tx_cfg.user_fcs <= user_fcs;
			tx_cfg.mac_pad_fcs <= ~user_fcs;
			tx_cfg.user_min_len <= user_fcs ? `LEN_MIN_USER : 16'h0000;
			tx_cfg.station_addr <= tx_vec[79:32];
			rx_cfg.len_unlimited <= rx_jumbo;
			rx_cfg.len_limit <= rx_limit;
			rx_cfg.station_addr <= rx_vec[79:32];
			pause_send <= pause_req & tx_vec[`B_FLOWCTL] & ~tx_ctrl_r[`B_RESET];
		end
	end

	// Read channel
	logic arready_r, rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	wire ar_take = s_axi_arvalid & arready_r;
	wire r_done = rvalid_r & s_axi_rready;
	wire rvalid_nxt = ar_take | (rvalid_r & ~r_done);
	wire [2:0] rd_idx = reg_index(s_axi_araddr);
	wire [31:0] status_word = {24'h0, tx_cfg.speed, tx_cfg.reset, tx_cfg.enable,
		rx_pending, tx_pending, rx_frame_active, tx_frame_active};
	wire [31:0] rd_word = (rd_idx == `IDX_TX_CTRL) ? tx_ctrl_r :
		(rd_idx == `IDX_TX_ADDR_LO) ? tx_addr_lo_r :
		(rd_idx == `IDX_TX_ADDR_HI) ? tx_addr_hi_r :
		(rd_idx == `IDX_RX_CTRL) ? rx_ctrl_r :
		(rd_idx == `IDX_RX_ADDR_LO) ? rx_addr_lo_r :
		(rd_idx == `IDX_RX_ADDR_HI) ? rx_addr_hi_r :
		(rd_idx == `IDX_STATUS) ? status_word : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_take) begin
				rdata_r <= rd_word;
				rresp_r <= (rd_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// ### testbench/mac_cfg_checker.sv
`timescale 1ns/10ps
`default_nettype none
module mac_cfg_checker import mac_cfg_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Frames and settings
	input wire logic tx_frame_active,
	input wire logic rx_frame_active,
	input wire logic pause_req,
	input wire tx_cfg_type tx_cfg,
	input wire rx_cfg_type rx_cfg,
	input wire logic pause_send
);
	localparam int TW = $bits(tx_cfg_type);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wlat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_wlat: assert property (p_wlat) else $error("write answer late");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_pause;
		pause_send == ($past(pause_req) && tx_cfg.pause_enable && !tx_cfg.reset); endproperty
	a_pause: assert property (p_pause) else $error("pause without cause");
	// Reset bit is left out: it may act in mid-frame
	property p_txhold;
		$past(tx_frame_active, 2) |-> $stable(tx_cfg[TW-2:0]); endproperty
	a_txhold: assert property (p_txhold) else $error("tx setting changed in frame");
	property p_rxhold;
		$past(rx_frame_active, 2) |-> $stable(rx_cfg); endproperty
	a_rxhold: assert property (p_rxhold) else $error("rx setting changed in frame");
	property p_fcs;
		tx_cfg.user_min_len == (tx_cfg.user_fcs ? 16'h0040 : 16'h0000); endproperty
	a_fcs: assert property (p_fcs) else $error("minimum length wrong");
	property p_spd;
		tx_cfg.speed != 2'h3; endproperty
	a_spd: assert property (p_spd) else $error("undefined speed");
	property p_ifg;
		tx_cfg.ifg_from_port |-> !tx_cfg.half_duplex; endproperty
	a_ifg: assert property (p_ifg) else $error("gap adjust in half duplex");
endmodule
bind mac_cfg_regs mac_cfg_checker mac_cfg_checker_inst (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.tx_frame_active, .rx_frame_active, .pause_req, .tx_cfg, .rx_cfg, .pause_send);
`default_nettype wire

// ### testbench/mac_frame_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stands in for the MAC datapath: one frame of fixed length per start
module mac_frame_model #(
	parameter int LEN = 40
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Start and frame state
	input wire logic go,
	output logic active
);
	logic [7:0] cnt_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) cnt_r <= 8'h00;
		else if (go && cnt_r == 8'h00) cnt_r <= 8'(LEN);
		else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
	end
	assign active = cnt_r != 8'h00;
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mac_cfg_regs.svh"
module tb_top import mac_cfg_pkg::*;;
	localparam int TW = $bits(tx_cfg_type);
	logic aclk = 1'b0, aresetn = 1'b0, pause_req = 1'b0, go_tx = 1'b0, go_rx = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, p;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic tx_frame_active, rx_frame_active, pause_send;
	tx_cfg_type tx_cfg, e;
	rx_cfg_type rx_cfg;
	int n_errors = 0, checked = 0, seed = 96, cyc = 0;
	logic [33:0] rdq[$], bq[$];
	logic [47:0] ta, ra;
	mac_cfg_regs mac_cfg_regs_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.tx_frame_active, .rx_frame_active, .pause_req, .tx_cfg, .rx_cfg, .pause_send);
	mac_frame_model mac_frame_model_inst (.aclk, .aresetn, .go(go_tx), .active(tx_frame_active));
	mac_frame_model mac_frame_model_rx_inst (.aclk, .aresetn, .go(go_rx), .active(rx_frame_active));
	always #5 aclk = ~aclk;
	task chk_bus(input logic [33:0] x, input logic [33:0] g);
		checked++;
		if (g !== x) begin
			n_errors++;
			$display("ERROR %0t bus got %h want %h", $time, g, x);
		end
	endtask
	task chk_cfg(input logic [TW-1:0] x, input logic [TW-1:0] g);
		checked++;
		if (g !== x) begin
			n_errors++;
			$display("ERROR %0t cfg got %h want %h", $time, g, x);
		end
	endtask
	task tally_and_finish;
		$display("errors %0d checked %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	function automatic tx_cfg_type exp_tx(input logic [31:0] v);
		logic [1:0] s;
		s = (v[13:12] == 2'h3) ? 2'h2 : v[13:12];
		return '{v[0], v[1], speed_type'(s), v[6], v[8] & ~v[6], v[5], v[4],
			v[14] ? v[31:16] : (v[2] ? `LEN_VLAN : `LEN_LEGAL), v[3], ~v[3],
			v[3] ? `LEN_MIN_USER : 16'h0000, ta};
	endfunction
	// Results are compared in arrival order against the notes of the drivers
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		pause_req <= 1'($random(seed));
		if (s_axi_rvalid && s_axi_rready) chk_bus(rdq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) chk_bus(bq.pop_front(), {s_axi_bresp, 32'h0});
		if (cyc == 5000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		bq.push_back({r, 32'h0});
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		while (!(aw && w)) begin
			@(posedge aclk);
			aw = aw | (s_axi_awready & s_axi_awvalid);
			w = w | (s_axi_wready & s_axi_wvalid);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid) @(posedge aclk);
		// Late ready exercises the slave holding its answer
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [33:0] x);
		rdq.push_back(x);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(12'h000, {2'h0, `TX_CTRL_RST});
		rd(12'h00c, {2'h0, `RX_CTRL_RST});
		rd(12'h01c, {2'h2, 32'h0});
		rd(12'h020, {2'h2, 32'h0});
		wr(12'h01c, 32'hffff_ffff, 2'h2);
		ta = 48'({$random(seed), $random(seed)});
		ra = 48'({$random(seed), $random(seed)});
		wr(12'h004, ta[31:0], 2'h0);
		wr(12'h008, {16'h0, ta[47:32]}, 2'h0);
		wr(12'h010, ra[31:0], 2'h0);
		wr(12'h014, {16'h0, ra[47:32]}, 2'h0);
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			d[13:12] = 2'(i);
			wr(12'h000, d, 2'h0);
			rd(12'h000, {2'h0, d & `TX_CTRL_MASK});
			repeat (3) @(posedge aclk);
			chk_cfg(exp_tx(d), tx_cfg);
		end
		for (int i = 0; i < 6; i++) begin
			d = $random(seed);
			d[31:16] = `LEN_LEGAL + 16'(d[23:16]);
			go_rx <= 1'b1;
			wr(12'h00c, d, 2'h0);
			go_rx <= 1'b0;
			while (rx_frame_active) @(posedge aclk);
			repeat (3) @(posedge aclk);
			chk_cfg(TW'(rx_cfg_type'{d[4], d[14] ? d[31:16] : `LEN_LEGAL, ra}), TW'(rx_cfg));
		end
		p = 32'h05ee_0020;
		wr(12'h000, p, 2'h0);
		repeat (3) @(posedge aclk);
		go_tx <= 1'b1;
		wr(12'h000, p | 32'h2, 2'h0);
		go_tx <= 1'b0;
		repeat (3) @(posedge aclk);
		chk_cfg(exp_tx(p), tx_cfg);
		wr(12'h000, p | 32'h3, 2'h0);
		repeat (2) @(posedge aclk);
		e = exp_tx(p);
		e.reset = 1'b1;
		chk_cfg(e, tx_cfg);
		while (tx_frame_active) @(posedge aclk);
		repeat (3) @(posedge aclk);
		chk_cfg(exp_tx(p | 32'h3), tx_cfg);
		rd(12'h018, {2'h0, 32'h0000_0030});
		// Speed was changed above, so the user resets the whole block
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		ta = 48'h0;
		chk_cfg(exp_tx(`TX_CTRL_RST), tx_cfg);
		chk_cfg(TW'(rx_cfg_type'{1'b0, `LEN_LEGAL, 48'h0}), TW'(rx_cfg));
		tally_and_finish;
	end
endmodule
`default_nettype wire
